// File: include/gpio_pkg.sv
// Shared constants and types for the port pin control block
package gpio_pkg;

  // ****************************************************************
  // Port geometry
  // ****************************************************************
  localparam int NUM_WIDE = 6;             // 8-bit ports A,B,C,E,G,L
  localparam int WIDE_W   = 8;
  localparam int NARROW_W = 4;             // Port F
  localparam int NUM_PORT = 7;

  // ****************************************************************
  // Register map: base + index * stride + kind
  // ****************************************************************
  localparam logic [7:0] PORT_BASE   = 8'hc0;
  localparam logic [1:0] OFS_DATA    = 2'h0;
  localparam logic [1:0] OFS_SETUP   = 2'h1;
  localparam logic [1:0] OFS_LEVEL   = 2'h2;
  localparam logic [2:0] IDX_A       = 3'h0;
  localparam logic [2:0] IDX_B       = 3'h1;
  localparam logic [2:0] IDX_C       = 3'h2;
  localparam logic [2:0] IDX_E       = 3'h3;
  localparam logic [2:0] IDX_G       = 3'h4;
  localparam logic [2:0] IDX_L       = 3'h5;
  localparam logic [2:0] IDX_F       = 3'h6;

  // ****************************************************************
  // Special port bit positions
  // ****************************************************************
  localparam int G_WDOG_BIT   = 1;
  localparam int G_INONLY_BIT = 6;
  localparam int G_CLKOUT_BIT = 7;
  localparam int G_IDLE_BIT   = 6;
  localparam int G_HALT_BIT   = 7;
  localparam int G_ALTSK_BIT  = 6;
  localparam int G_DELAY_BIT  = 7;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam int RESTART_DELAY_CYCLES = 32;

  // Power mode states
  typedef enum logic [3:0] {
    PWR_RUN     = 4'b0001,
    PWR_IDLE    = 4'b0010,
    PWR_HALT    = 4'b0100,
    PWR_RESTART = 4'b1000
  } power_state_t;

endpackage

// File: src/port_bank.sv
// One I/O port: setup and output registers, pin drive and input sampling
module port_bank
  import gpio_pkg::*;
#(
  parameter int WIDTH = WIDE_W
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // Register writes
  input  wire logic             wr_data_i,
  input  wire logic             wr_setup_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // Per-bit override of the pin setup
  input  wire logic [WIDTH-1:0] force_mask_i,
  input  wire logic [WIDTH-1:0] force_oe_i,
  input  wire logic [WIDTH-1:0] force_out_i,
  input  wire logic [WIDTH-1:0] force_pu_i,
  // Pins
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_o,
  output logic      [WIDTH-1:0] pullup_o,
  // Register contents
  output logic      [WIDTH-1:0] setup_o,
  output logic      [WIDTH-1:0] data_o,
  output logic      [WIDTH-1:0] level_o
);

  // Widths the register bytes cannot hold are refused
  if (WIDTH < 1 || WIDTH > WIDE_W) begin : g_bad_width
    $error("port_bank WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] sync_first;
  logic [WIDTH-1:0] next_oe;
  logic [WIDTH-1:0] next_out;
  logic [WIDTH-1:0] next_pu;

  // Setup bit drives the pin, else data bit picks pull-up or Hi-Z
  assign next_oe  = (force_mask_i & force_oe_i)
                  | (~force_mask_i & setup_o);
  assign next_out = (force_mask_i & force_out_i)
                  | (~force_mask_i & data_o);
  assign next_pu  = (force_mask_i & force_pu_i)
                  | (~force_mask_i & ~setup_o & data_o);

  // Configuration and output value registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      setup_o <= SETUP_RST[WIDTH-1:0];
      data_o  <= DATA_RST[WIDTH-1:0];
    end else begin
      if (wr_setup_i) setup_o <= wdata_i;
      if (wr_data_i)  data_o  <= wdata_i;
    end
  end

  // Registered pin drive
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
      pullup_o <= '0;
    end else begin
      pin_o    <= next_out;
      pin_oe_o <= next_oe;
      pullup_o <= next_pu;
    end
  end

  // Two-stage pin sampler, read in every setup
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_first <= '0;
      level_o    <= '0;
    end else begin
      sync_first <= pin_i;
      level_o    <= sync_first;
    end
  end

endmodule // port_bank

// File: src/port_pin_control.sv
// Port pin control: six 8-bit ports, one 4-bit port, power mode bits
module port_pin_control
  import gpio_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                            clock_i,
  input  wire logic                            rstn_i,
  // Data memory access
  input  wire logic [7:0]                      addr_i,
  input  wire logic                            wr_en_i,
  input  wire logic [7:0]                      wdata_i,
  input  wire logic                            rd_en_i,
  output logic      [7:0]                      rdata_o,
  // 8-bit port pins, index A,B,C,E,G,L
  input  wire logic [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_i,
  output logic      [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_o,
  output logic      [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_oe_o,
  output logic      [NUM_WIDE-1:0][WIDE_W-1:0] wide_pullup_o,
  // 4-bit port pins
  input  wire logic [NARROW_W-1:0]             narrow_pin_i,
  output logic      [NARROW_W-1:0]             narrow_pin_o,
  output logic      [NARROW_W-1:0]             narrow_pin_oe_o,
  output logic      [NARROW_W-1:0]             narrow_pullup_o,
  // Watchdog and clock options, wake pin
  input  wire logic                            watchdog_select_i,
  input  wire logic                            watchdog_level_i,
  input  wire logic                            rc_clock_option_i,
  input  wire logic                            wake_i,
  // Power mode and serial control
  output logic                                 halt_mode_o,
  output logic                                 idle_mode_o,
  output logic                                 osc_run_o,
  output logic                                 oscillator_clock_output,
  output logic                                 alt_shift_phase_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************

  if (RESTART_CYCLES < 1 || RESTART_CYCLES > 65535) begin : g_bad_delay
    $error("RESTART_CYCLES must be 1 to 65535");
  end

  localparam int CW = $clog2(RESTART_CYCLES + 1);
  localparam logic [CW-1:0] RESTART_LOAD = CW'(RESTART_CYCLES);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  logic [7:0] offset;
  logic [2:0] port_idx;
  logic [1:0] reg_kind;
  logic       addr_hit;
  logic       wr_hit;
  logic       wr_g_data;

  // Three byte registers per port at a stride of four
  assign offset    = addr_i - PORT_BASE;
  assign port_idx  = offset[4:2];
  assign reg_kind  = offset[1:0];
  assign addr_hit  = (offset[7:5] == 3'h0)
                   && (port_idx <= IDX_F)
                   && (reg_kind != 2'h3);
  assign wr_hit    = wr_en_i && addr_hit;
  assign wr_g_data = wr_hit && (port_idx == IDX_G)
                   && (reg_kind == OFS_DATA);

  // ****************************************************************
  // Port register banks
  // ****************************************************************

  logic [NUM_PORT-1:0][WIDE_W-1:0] setup_all;
  logic [NUM_PORT-1:0][WIDE_W-1:0] data_all;
  logic [NUM_PORT-1:0][WIDE_W-1:0] level_all;
  logic [NUM_WIDE-1:0][WIDE_W-1:0] fmask;
  logic [NUM_WIDE-1:0][WIDE_W-1:0] foe;
  logic [NUM_WIDE-1:0][WIDE_W-1:0] fout;
  logic [NUM_WIDE-1:0][WIDE_W-1:0] fpu;
  logic [WIDE_W-1:0]               g_mask;
  logic [WIDE_W-1:0]               g_oe;
  logic [WIDE_W-1:0]               g_out;
  logic [WIDE_W-1:0]               g_pu;
  logic [NARROW_W-1:0]             f_setup;
  logic [NARROW_W-1:0]             f_data;
  logic [NARROW_W-1:0]             f_level;
  logic                            clk_toggle;

  // Special port overrides: input-only, clock output, watchdog pin
  always_comb begin
    g_mask = '0;
    g_oe   = '0;
    g_out  = '0;
    g_pu   = '0;
    g_mask[G_INONLY_BIT] = 1'b1;
    g_oe[G_INONLY_BIT]   = 1'b0;
    g_pu[G_INONLY_BIT]   = 1'b0;
    g_mask[G_CLKOUT_BIT] = 1'b1;
    g_oe[G_CLKOUT_BIT]   = 1'b1;
    g_out[G_CLKOUT_BIT]  = clk_toggle;
    g_mask[G_WDOG_BIT]   = watchdog_select_i;
    g_oe[G_WDOG_BIT]     = watchdog_level_i;
    g_out[G_WDOG_BIT]    = 1'b0;
    g_pu[G_WDOG_BIT]     = 1'b1;
  end

  // One bank per 8-bit port; only the special port gets overrides
  for (genvar gi = 0; gi < NUM_WIDE; gi++) begin : g_wide
    localparam logic [2:0] PI = 3'(gi);

    assign fmask[gi] = (PI == IDX_G) ? g_mask : '0;
    assign foe[gi]   = (PI == IDX_G) ? g_oe   : '0;
    assign fout[gi]  = (PI == IDX_G) ? g_out  : '0;
    assign fpu[gi]   = (PI == IDX_G) ? g_pu   : '0;

    port_bank #(
      .WIDTH (WIDE_W)
    ) u_bank (
      .clock_i      (clock_i),
      .rstn_i       (rstn_i),
      .wr_data_i    (wr_hit && port_idx == PI
                     && reg_kind == OFS_DATA),
      .wr_setup_i   (wr_hit && port_idx == PI
                     && reg_kind == OFS_SETUP),
      .wdata_i      (wdata_i),
      .force_mask_i (fmask[gi]),
      .force_oe_i   (foe[gi]),
      .force_out_i  (fout[gi]),
      .force_pu_i   (fpu[gi]),
      .pin_i        (wide_pin_i[gi]),
      .pin_o        (wide_pin_o[gi]),
      .pin_oe_o     (wide_pin_oe_o[gi]),
      .pullup_o     (wide_pullup_o[gi]),
      .setup_o      (setup_all[gi]),
      .data_o       (data_all[gi]),
      .level_o      (level_all[gi])
    );
  end

  // The 4-bit port
  port_bank #(
    .WIDTH (NARROW_W)
  ) u_narrow (
    .clock_i      (clock_i),
    .rstn_i       (rstn_i),
    .wr_data_i    (wr_hit && port_idx == IDX_F
                   && reg_kind == OFS_DATA),
    .wr_setup_i   (wr_hit && port_idx == IDX_F
                   && reg_kind == OFS_SETUP),
    .wdata_i      (wdata_i[NARROW_W-1:0]),
    .force_mask_i ('0),
    .force_oe_i   ('0),
    .force_out_i  ('0),
    .force_pu_i   ('0),
    .pin_i        (narrow_pin_i),
    .pin_o        (narrow_pin_o),
    .pin_oe_o     (narrow_pin_oe_o),
    .pullup_o     (narrow_pullup_o),
    .setup_o      (f_setup),
    .data_o       (f_data),
    .level_o      (f_level)
  );

  // Narrow port widened; upper bits read as zero
  assign setup_all[IDX_F] = {4'h0, f_setup};
  assign data_all[IDX_F]  = {4'h0, f_data};
  assign level_all[IDX_F] = {4'h0, f_level};

  // ****************************************************************
  // Read path
  // ****************************************************************

  logic [7:0] data_view;
  logic [7:0] next_rdata;

  // Special port hides its input-only and clock output data bits
  always_comb begin
    data_view = data_all[port_idx];
    if (port_idx == IDX_G) begin
      data_view[G_INONLY_BIT] = 1'b0;
      data_view[G_CLKOUT_BIT] = 1'b0;
    end
  end

  // Pick the register by kind; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (addr_hit) begin
      case (reg_kind)
        OFS_DATA:  next_rdata = data_view;
        OFS_SETUP: next_rdata = setup_all[port_idx];
        OFS_LEVEL: next_rdata = level_all[port_idx];
        default:   next_rdata = 8'h00;
      endcase
    end
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      rdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // Serial clock phase
  // ****************************************************************

  // Alternate shift clock phase follows special setup bit 6
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alt_shift_phase_o <= 1'b0;
    end else begin
      alt_shift_phase_o <= setup_all[IDX_G][G_ALTSK_BIT];
    end
  end

  // ****************************************************************
  // Power modes
  // ****************************************************************

  power_state_t    state;
  power_state_t    next_state;
  logic [CW-1:0]   delay_cnt;
  logic [CW-1:0]   next_delay;
  logic            wake_first;
  logic            wake_sync;
  logic            delay_wanted;

  // Wake pin comes from outside the clock domain
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_first <= 1'b0;
      wake_sync  <= 1'b0;
    end else begin
      wake_first <= wake_i;
      wake_sync  <= wake_first;
    end
  end

  assign delay_wanted = setup_all[IDX_G][G_DELAY_BIT]
                      && rc_clock_option_i;

  // Mode sequencer; halt wins when both mode bits are written
  always_comb begin
    next_state = state;
    next_delay = delay_cnt;
    case (state)
      PWR_RUN: begin
        if (wr_g_data && wdata_i[G_HALT_BIT]) begin
          next_state = PWR_HALT;
        end else if (wr_g_data && wdata_i[G_IDLE_BIT]) begin
          next_state = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (wake_sync) next_state = PWR_RUN;
      end
      PWR_HALT: begin
        if (wake_sync && delay_wanted) begin
          next_state = PWR_RESTART;
          next_delay = RESTART_LOAD;
        end else if (wake_sync) begin
          next_state = PWR_RUN;
        end
      end
      PWR_RESTART: begin
        next_delay = delay_cnt - CW'(1);
        if (delay_cnt <= CW'(1)) next_state = PWR_RUN;
      end
      default: begin
        next_state = PWR_RUN;
      end
    endcase
  end

  // State and start-up counter
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state     <= PWR_RUN;
      delay_cnt <= '0;
    end else begin
      state     <= next_state;
      delay_cnt <= next_delay;
    end
  end

  // Mode outputs registered from the next state
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      halt_mode_o <= 1'b0;
      idle_mode_o <= 1'b0;
      osc_run_o   <= 1'b1;
    end else begin
      halt_mode_o <= (next_state == PWR_HALT);
      idle_mode_o <= (next_state == PWR_IDLE);
      osc_run_o   <= (next_state == PWR_RUN)
                  || (next_state == PWR_IDLE);
    end
  end

  // ****************************************************************
  // Oscillator clock output
  // ****************************************************************

  // Divided clock that freezes low while the oscillator is stopped
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_toggle <= 1'b0;
    end else if (osc_run_o) begin
      clk_toggle <= ~clk_toggle;
    end else begin
      clk_toggle <= 1'b0;
    end
  end

  // Registered copy, one cycle behind, for the clock consumers inside the chip
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oscillator_clock_output <= 1'b0;
    end else begin
      oscillator_clock_output <= clk_toggle;
    end
  end

endmodule // port_pin_control

// File: tb/port_pin_control_checker.sv
// Concurrent checks on the port pin control block's ports
module port_pin_control_checker
  import gpio_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic                            clock_i,
  input wire logic                            rstn_i,
  // Register access
  input wire logic [7:0]                      addr_i,
  input wire logic                            wr_en_i,
  input wire logic [7:0]                      wdata_i,
  input wire logic                            rd_en_i,
  input wire logic [7:0]                      rdata_o,
  // Pins of the 8-bit ports
  input wire logic [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_o,
  input wire logic [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_oe_o,
  input wire logic [NUM_WIDE-1:0][WIDE_W-1:0] wide_pullup_o,
  // Options and power modes
  input wire logic                            watchdog_select_i,
  input wire logic                            watchdog_level_i,
  input wire logic                            halt_mode_o,
  input wire logic                            idle_mode_o,
  input wire logic                            osc_run_o,
  input wire logic                            oscillator_clock_output
);
  timeunit 1ns;
  timeprecision 100ps;
  // Watchdog pin may drive low with its pull-up on while selected
  localparam logic [NUM_WIDE-1:0][WIDE_W-1:0] WDOG_PIN = 48'h0002_0000_0000;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // ****************************************************************
  // Pin setup
  // ****************************************************************
  a_g6_input_only: assert property (
    !wide_pin_oe_o[4][6] && !wide_pullup_o[4][6])
    else $error("input-only pin driven or pulled up");
  a_g7_clock_out: assert property ($past(rstn_i) |->
    wide_pin_oe_o[4][7]) else $error("clock output pin not driven");
  a_setup_drive: assert property (wr_en_i && addr_i == 8'hc1 |->
    ##2 wide_pin_oe_o[0] == $past(wdata_i, 2))
    else $error("drive enable does not follow setup write");
  a_pullup_excl: assert property (
    (wide_pullup_o & wide_pin_oe_o
     & ~($past(watchdog_select_i) ? WDOG_PIN : '0)) == '0)
    else $error("pull-up on while driving");
  a_watchdog_pin: assert property (
    $past(watchdog_select_i) && $past(rstn_i) |-> wide_pullup_o[4][1]
    && !wide_pin_o[4][1]
    && wide_pin_oe_o[4][1] == $past(watchdog_level_i))
    else $error("watchdog pin not ruled by watchdog");

  // ****************************************************************
  // Reads and power modes
  // ****************************************************************
  a_unmapped_zero: assert property (
    rd_en_i && addr_i[1:0] == 2'h3 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_g_data_hidden: assert property (
    rd_en_i && addr_i == 8'hd0 |=> rdata_o[7:6] == 2'b00)
    else $error("special data bits not read as zero");
  a_halt_entry: assert property (wr_en_i && addr_i == 8'hd0
    && wdata_i[7] && osc_run_o && !halt_mode_o && !idle_mode_o
    |=> halt_mode_o && !idle_mode_o && !osc_run_o)
    else $error("halt not entered");
  a_idle_entry: assert property (wr_en_i && addr_i == 8'hd0
    && wdata_i[7:6] == 2'b01 && osc_run_o && !halt_mode_o
    && !idle_mode_o |=> idle_mode_o && !halt_mode_o && osc_run_o)
    else $error("idle not entered");
  a_clock_frozen: assert property (
    !osc_run_o && !$past(osc_run_o) && !$past(osc_run_o, 2)
    |-> !oscillator_clock_output)
    else $error("clock output runs while oscillator stopped");

  c_halt_left: cover property (halt_mode_o ##1 !halt_mode_o);
  c_idle: cover property (idle_mode_o);
  c_g_read: cover property (rd_en_i && addr_i == 8'hd0);
endmodule // port_pin_control_checker

bind port_pin_control port_pin_control_checker #(
  .RESTART_CYCLES(RESTART_CYCLES)
) port_pin_control_checker_inst (
  .clock_i, .rstn_i, .addr_i, .wr_en_i, .wdata_i, .rd_en_i, .rdata_o,
  .wide_pin_o, .wide_pin_oe_o, .wide_pullup_o, .watchdog_select_i,
  .watchdog_level_i, .halt_mode_o, .idle_mode_o, .osc_run_o,
  .oscillator_clock_output
);

// File: tb/pin_world.sv
// External circuits on the port pins: drivers, pull-ups, floating pads
module pin_world
  import gpio_pkg::*;
(
  // Clock
  input  wire logic        clock_i,
  // Device side of all 52 pins
  input  wire logic [51:0] out_i,
  input  wire logic [51:0] oe_i,
  input  wire logic [51:0] pu_i,
  // External driver set by the bench
  input  wire logic        ext_en_i,
  input  wire logic [7:0]  ext_val_i,
  // Resolved pin levels
  output logic      [51:0] level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        flip = 1'b0;
  logic [51:0] ext;
  logic [51:0] en;

  // Undriven pads wander so a stale value is never read back
  always @(posedge clock_i) flip <= ~flip;
  assign ext = {ext_val_i[3:0], {NUM_WIDE{ext_val_i}}};
  assign en  = {52{ext_en_i}};
  // Device drive first, then the outside driver, then pull-up or float
  assign level_o = (oe_i & out_i) | (~oe_i & en & ext)
                 | (~oe_i & ~en & (pu_i | {52{flip}}));
endmodule // pin_world

// File: tb/multi_port_pin_control_test.sv
// Self-checking bench for the port pin control block
module multi_port_pin_control_test
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RST_CYC = 2;
  logic clock_i, rstn_i, wr_en_i, rd_en_i, ext_en, wake_i;
  logic watchdog_select_i, watchdog_level_i, rc_clock_option_i;
  logic halt_mode_o, idle_mode_o, osc_run_o;
  logic oscillator_clock_output, alt_shift_phase_o;
  logic [7:0] addr_i, wdata_i, rdata_o, ext_val, w, oe, pu, po;
  logic [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_i, wide_pin_o;
  logic [NUM_WIDE-1:0][WIDE_W-1:0] wide_pin_oe_o, wide_pullup_o;
  logic [NARROW_W-1:0] narrow_pin_i, narrow_pin_o;
  logic [NARROW_W-1:0] narrow_pin_oe_o, narrow_pullup_o;
  logic [51:0] level;
  int bad_count, tests_run, n;

  port_pin_control #(.RESTART_CYCLES(RST_CYC)) port_pin_control_inst (
    .clock_i, .rstn_i, .addr_i, .wr_en_i, .wdata_i, .rd_en_i, .rdata_o,
    .wide_pin_i, .wide_pin_o, .wide_pin_oe_o, .wide_pullup_o,
    .narrow_pin_i, .narrow_pin_o, .narrow_pin_oe_o, .narrow_pullup_o,
    .watchdog_select_i, .watchdog_level_i, .rc_clock_option_i, .wake_i,
    .halt_mode_o, .idle_mode_o, .osc_run_o, .oscillator_clock_output,
    .alt_shift_phase_o);
  pin_world pin_world_inst (
    .clock_i, .out_i({narrow_pin_o, wide_pin_o}),
    .oe_i({narrow_pin_oe_o, wide_pin_oe_o}),
    .pu_i({narrow_pullup_o, wide_pullup_o}), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(level));
  assign wide_pin_i   = level[47:0];
  assign narrow_pin_i = level[51:48];

  // ****************************************************************
  // Clock, access tasks and verdict
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] ad(input int p, input logic [1:0] k);
    return PORT_BASE + 8'(4 * p) + {6'h0, k};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    addr_i  = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    tick(1);
    wr_en_i = 1'b0;
  endtask
  // Read answer lands on the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, exp, m);
    tick(1);
    addr_i  = a;
    rd_en_i = 1'b1;
    tick(1);
    rd_en_i = 1'b0;
    chk(rdata_o & m, exp & m);
  endtask
  task automatic wake_up();
    wake_i = 1'b1;
    for (int i = 0; i < 20 && (halt_mode_o !== 1'b0
         || idle_mode_o !== 1'b0); i++) tick(1);
    wake_i = 1'b0;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    final_report();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {rstn_i, wr_en_i, rd_en_i, ext_en, wake_i} = '0;
    {addr_i, wdata_i, ext_val, bad_count, tests_run} = '0;
    {watchdog_select_i, watchdog_level_i, rc_clock_option_i} = '0;
    repeat (8) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    // Reset contents of every port
    for (int p = 0; p < NUM_PORT; p++) begin
      rd(ad(p, OFS_DATA), DATA_RST, 8'hff);
      rd(ad(p, OFS_SETUP), SETUP_RST, 8'hff);
    end
    // All four setups on each plain 8-bit port, high and low drive only on port F, outside driver on inputs
    ext_en  = 1'b1;
    ext_val = 8'h3c;
    for (int p = 0; p < NUM_PORT; p++) begin
      if (p != IDX_G) begin
        w = (p == IDX_F) ? 8'h0f : 8'hff;
        wr(ad(p, OFS_DATA), 8'ha5);
        wr(ad(p, OFS_SETUP), 8'h0f);
        rd(ad(p, OFS_DATA), 8'ha5 & w, 8'hff);
        rd(ad(p, OFS_SETUP), 8'h0f & w, 8'hff);
        rd(ad(p, OFS_LEVEL), 8'h35 & w, 8'hff);
        oe = (p == IDX_F) ? {4'h0, narrow_pin_oe_o} : wide_pin_oe_o[p];
        pu = (p == IDX_F) ? {4'h0, narrow_pullup_o} : wide_pullup_o[p];
        po = (p == IDX_F) ? {4'h0, narrow_pin_o} : wide_pin_o[p];
        chk(oe, 8'h0f & w);
        chk(pu, 8'ha0 & w);
        chk(po & oe, 8'h05 & w);
      end
    end
    // Unmapped slot and read-only level register
    wr(8'hc3, 8'hff);
    rd(8'hc3, 8'h00, 8'hff);
    wr(ad(0, OFS_LEVEL), 8'h00);
    rd(ad(0, OFS_DATA), 8'ha5, 8'hff);
    // Special port: input-only, clock output, serial phase
    wr(ad(IDX_G, OFS_DATA), 8'h2d);
    wr(ad(IDX_G, OFS_SETUP), 8'h7f);
    tick(2); // Let the new drive pass the pin sampler
    rd(ad(IDX_G, OFS_LEVEL), 8'h2d, 8'h7f);
    chk(wide_pin_oe_o[IDX_G], 8'hbf);
    chk({7'h0, wide_pullup_o[IDX_G][G_INONLY_BIT]}, 8'h00);
    chk({7'h0, alt_shift_phase_o}, 8'h01);
    // Watchdog owns its pin whatever setup bit 1 says
    watchdog_select_i = 1'b1;
    for (int l = 0; l < 2; l++) begin
      watchdog_level_i = l[0];
      tick(3);
      chk({5'h0, wide_pin_o[IDX_G][1], wide_pin_oe_o[IDX_G][1],
           wide_pullup_o[IDX_G][1]}, {6'h0, l[0], 1'b1});
    end
    watchdog_select_i = 1'b0;
    tick(3);
    chk({7'h0, wide_pin_oe_o[IDX_G][1]}, 8'h01);
    // Halt wins over idle when both bits are written
    wr(ad(IDX_G, OFS_DATA), 8'hc2);
    chk({5'h0, halt_mode_o, idle_mode_o, osc_run_o}, 8'h04);
    tick(3);
    chk({7'h0, oscillator_clock_output}, 8'h00);
    wake_up();
    chk({5'h0, halt_mode_o, idle_mode_o, osc_run_o}, 8'h01);
    rd(ad(IDX_G, OFS_DATA), 8'h02, 8'hff);
    // Clock output pin and its copy toggle every cycle while running
    po = {6'h0, wide_pin_o[IDX_G][7], oscillator_clock_output};
    tick(1);
    chk({6'h0, po[1:0] ^ {wide_pin_o[IDX_G][7],
         oscillator_clock_output}}, 8'h03);
    // Idle, then a halt request that must be ignored while idle
    wr(ad(IDX_G, OFS_DATA), 8'h40);
    chk({5'h0, halt_mode_o, idle_mode_o, osc_run_o}, 8'h03);
    wr(ad(IDX_G, OFS_DATA), 8'h80);
    chk({5'h0, halt_mode_o, idle_mode_o, osc_run_o}, 8'h03);
    wake_up();
    // Restart delay after halt with the RC clock option
    rc_clock_option_i = 1'b1;
    wr(ad(IDX_G, OFS_SETUP), 8'h80);
    wr(ad(IDX_G, OFS_DATA), 8'h80);
    wake_up();
    chk({7'h0, osc_run_o}, 8'h00);
    n = 0;
    while (osc_run_o !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk({7'h0, n >= RST_CYC - 1 && n <= RST_CYC + 1}, 8'h01);
    final_report();
  end
endmodule // multi_port_pin_control_test
